// ==== verilog/eepc_pkg.sv ====
/*
 * Shared constants and types of the serial EEPROM command block: opcodes,
 * status bit positions, protection bounds, array geometry and write timing.
 * Assumes the system clock runs at 20 MHz and the serial clock comes from the host.
 */
// Functional notes
// RULE1: Busy flag reads 1 throughout internal write, 0 when idle; host cannot write it.
// RULE2: Set-latch command sets write latch, clear-latch command clears it.
// RULE3: Block-protect bits change only by status write and survive power cycles.
// RULE4: Protect codes: 00 none, 01 6000-7FFF, 10 4000-7FFF, 11 whole array.
// RULE5: Guard pin low with enable bit set blocks status and protected writes.
// RULE6: Latch clear refuses all writes; protected blocks never writable.
// RULE7: Status layout: enable bit 7, zeros 6-4, protect hi 3, lo 2, latch 1, busy 0.
// RULE8: Status write changes only bits 2, 3 and 7.
// RULE9: Latch starts cleared; writes without prior set-latch are ignored.
// RULE10: Memory write takes effect only outside the protected region.
// RULE11: Latch is set only when chip select rises after the set-latch command.
// RULE12: Write is opcode, 16 address bits, data; address bit 15 ignored.
// RULE13: Internal cycle and busy start on chip select rise after valid write.
// RULE14: During internal write only status read is obeyed.
// RULE15: Up to 64 bytes per page; in-page address wraps, overwriting earlier bytes.
// RULE16: Completed memory or status write clears the latch.
// RULE17: Status read during internal write returns all ones.
// RULE18: Guard pin falling while selected aborts a status write; later falls ignored.
// RULE19: Read streams bytes after address, incrementing and wrapping over the whole array.
// RULE20: Chip select rise ends a read; output released, read context dropped.
// RULE21: Opcodes: set-latch 06, clear-latch 04, status read 05.
// RULE22: Status write 01, read 03, write 02; others ignored, output undriven.
// RULE23: Input sampled on rising clock, output changed on falling clock.
// RULE24: Chip select high keeps output released; each session framed by select edges.
// RULE25: Refused write starts no cycle, sets no busy and keeps the latch.
// RULE26: Write time is a cycle count; accept only at byte boundary after data.
`default_nettype none

package eepc_pkg;

	// Command opcodes
	localparam logic [7:0] OP_SET_LATCH = 8'h06;
	localparam logic [7:0] OP_CLR_LATCH = 8'h04;
	localparam logic [7:0] OP_STAT_RD   = 8'h05;
	localparam logic [7:0] OP_STAT_WR   = 8'h01;
	localparam logic [7:0] OP_ARR_RD    = 8'h03;
	localparam logic [7:0] OP_ARR_WR    = 8'h02;

	// Status register bit positions
	localparam int SR_BUSY   = 0;
	localparam int SR_LATCH  = 1;
	localparam int SR_BP_LO  = 2;
	localparam int SR_BP_HI  = 3;
	localparam int SR_HWPE   = 7;
	localparam logic [7:0] SR_BUSY_READ = 8'hff;
	localparam logic [2:0] NV_RESET     = 3'h0;

	// Array geometry
	localparam int ADDR_W = 15;
	localparam int PAGE_W = 9;
	localparam int OFFS_W = 6;
	localparam int PAGE_BYTES = 64;

	// Protection codes and lower bounds
	localparam logic [1:0] BP_NONE = 2'h0;
	localparam logic [1:0] BP_QTR  = 2'h1;
	localparam logic [1:0] BP_HALF = 2'h2;
	localparam logic [1:0] BP_FULL = 2'h3;
	localparam logic [14:0] PROT_QTR_BASE  = 15'h6000;
	localparam logic [14:0] PROT_HALF_BASE = 15'h4000;

	// Write cycle timing
	localparam int WRITE_TIME_NS = 5000000;
	localparam int CLK_PERIOD_NS = 50;
	localparam int WRITE_CYCLES_DEF = WRITE_TIME_NS / CLK_PERIOD_NS;
	localparam int TIMER_W = 17;

	typedef enum logic [1:0] {EEPC_IDLE, EEPC_PROG, EEPC_WAIT} eepc_sys_st_t;
	typedef enum logic [2:0] {PH_OPC, PH_ADDR, PH_WDAT, PH_SDAT, PH_READ, PH_STAT, PH_IGN}
		eepc_ph_t;
	typedef enum logic [2:0] {K_NONE, K_SET, K_CLR, K_SWR, K_AWR, K_ARD} eepc_kind_t;

endpackage

`default_nettype wire

// ==== verilog/eepc_sync.sv ====
/*
 * Two-stage level synchroniser for a small vector.
 * Assumes each bit is a slow level; bits are not coherent with each other.
 */
`default_nettype none

module eepc_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_in,
	input  wire logic         reset_n_in,
	input  wire logic [W-1:0] d_in,
	output logic      [W-1:0] q_out
);

	logic [W-1:0] meta;

	// First stage feeds only the second
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			meta  <= '0;
			q_out <= '0;
		end else begin
			meta  <= d_in;
			q_out <= meta;
		end
	end

endmodule

`default_nettype wire

// ==== verilog/eepc_mem.sv ====
/*
 * Storage: the 32K byte array, the 64 byte page buffer and the three
 * nonvolatile status bits. Array and status bit writes run on the system
 * clock; buffer writes on the serial clock; reads are asynchronous.
 * Assumes array writes and array reads never overlap (busy gating).
 */
`default_nettype none

module eepc_mem
	import eepc_pkg::*;
(
	input  wire logic              clk_sys_in,
	input  wire logic              clk_link_in,
	input  wire logic              arr_we_in,
	input  wire logic [ADDR_W-1:0] arr_waddr_in,
	input  wire logic [7:0]        arr_wdata_in,
	input  wire logic [ADDR_W-1:0] arr_raddr_in,
	output logic      [7:0]        arr_rdata_out,
	input  wire logic              buf_we_in,
	input  wire logic [OFFS_W-1:0] buf_widx_in,
	input  wire logic [7:0]        buf_wdata_in,
	input  wire logic [OFFS_W-1:0] buf_ridx_in,
	output logic      [7:0]        buf_rdata_out,
	input  wire logic              nv_we_in,
	input  wire logic [2:0]        nv_wdata_in,
	output logic      [2:0]        nv_out
);

	logic [7:0] arr [0:(1<<ADDR_W)-1];
	logic [7:0] page_buf [0:PAGE_BYTES-1];
	logic [2:0] nv_bits = NV_RESET;	// No reset: survives power cycles

	// Array programming
	always_ff @(posedge clk_sys_in) begin
		if (arr_we_in) begin
			arr[arr_waddr_in] <= arr_wdata_in;
		end
	end

	// Nonvolatile status bits
	always_ff @(posedge clk_sys_in) begin
		if (nv_we_in) begin
			nv_bits <= nv_wdata_in;	// RULE3
		end
	end

	// Page buffer loading from the serial side
	always_ff @(posedge clk_link_in) begin
		if (buf_we_in) begin
			page_buf[buf_widx_in] <= buf_wdata_in;
		end
	end

	// Asynchronous read ports
	assign arr_rdata_out = arr[arr_raddr_in];
	assign buf_rdata_out = page_buf[buf_ridx_in];
	assign nv_out        = nv_bits;

endmodule

`default_nettype wire

// ==== verilog/eepc_top.sv ====
/*
 * Serial EEPROM command block. The serial side (shifting, decode, page
 * loading, read streaming) runs on the host serial clock; write acceptance,
 * the write latch, busy and programming run on the system clock.
 * Assumes the host keeps chip select high at least three system clocks
 * between frames, so frame results are sampled while the serial clock rests.
 */
`default_nettype none

module eepc_top
	import eepc_pkg::*;
#(
	parameter int unsigned WRITE_CYCLES = WRITE_CYCLES_DEF
) (
	input  wire logic clk_sys_in,
	input  wire logic reset_n_in,
	input  wire logic spi_sck_in,
	input  wire logic spi_cs_n_in,
	input  wire logic spi_si_in,
	input  wire logic spi_wguard_n_in,
	output logic      spi_so_out,
	output logic      spi_so_oe_out
);

	typedef struct packed {
		eepc_ph_t         ph;
		logic [3:0]       cnt;
		logic [7:0]       sr;
		logic [15:0]      addr;
		eepc_kind_t       kind;
		logic             byte_seen;
		logic             boundary;
		logic [7:0]       stat_data;
		logic [PAGE_W-1:0] page;
		logic [OFFS_W-1:0] offs;
		logic [PAGE_BYTES-1:0] mask;
		logic [7:0]       tx;
		logic             tx_on;
		logic [ADDR_W-1:0] rd_ptr;
	} eepc_link_t;

	typedef struct packed {
		eepc_sys_st_t st;
		logic         cs_q;
		logic         wg_q;
		logic         latch;
		logic         busy;
		logic         abort;
		logic [6:0]   idx;
		logic [TIMER_W-1:0] timer;
	} eepc_sys_t;

	localparam logic [TIMER_W-1:0] TIMER_LAST = TIMER_W'(WRITE_CYCLES - 1);

	eepc_link_t lk;
	eepc_link_t next_lk;
	eepc_sys_t  sy;
	eepc_sys_t  next_sy;

	logic              fresh;
	logic              link_clr;
	logic [1:0]        pins_s;
	logic [4:0]        stat_s;
	logic [2:0]        nv;
	logic [ADDR_W-1:0] rd_addr;
	logic [7:0]        rd_data;
	logic              buf_we;
	logic [7:0]        buf_rdata;
	logic              arr_we;
	logic              nv_we;
	logic [7:0]        stat_byte;
	logic              cs_s;
	logic              wg_s;
	logic              hw_lock;
	logic              page_prot;

	assign cs_s = ~pins_s[1];
	assign wg_s = ~pins_s[0];

	// Pins pass inverted so the synchroniser's reset value reads as idle
	eepc_sync #(.W(2)) u_pin_sync (
		.clk_in     (clk_sys_in),
		.reset_n_in (reset_n_in),
		.d_in       ({~spi_cs_n_in, ~spi_wguard_n_in}),
		.q_out      (pins_s)
	);

	// Status levels carried to the serial side
	eepc_sync #(.W(5)) u_stat_sync (
		.clk_in     (spi_sck_in),
		.reset_n_in (reset_n_in),
		.d_in       ({nv, sy.latch, sy.busy}),
		.q_out      (stat_s)
	);

	eepc_mem u_mem (
		.clk_sys_in    (clk_sys_in),
		.clk_link_in   (spi_sck_in),
		.arr_we_in     (arr_we),
		.arr_waddr_in  ({lk.page, sy.idx[OFFS_W-1:0]}),
		.arr_wdata_in  (buf_rdata),
		.arr_raddr_in  (rd_addr),
		.arr_rdata_out (rd_data),
		.buf_we_in     (buf_we),
		.buf_widx_in   (lk.offs),
		.buf_wdata_in  ({lk.sr[6:0], spi_si_in}),
		.buf_ridx_in   (sy.idx[OFFS_W-1:0]),
		.buf_rdata_out (buf_rdata),
		.nv_we_in      (nv_we),
		.nv_wdata_in   ({lk.stat_data[SR_HWPE], lk.stat_data[SR_BP_HI], lk.stat_data[SR_BP_LO]}),
		.nv_out        (nv)
	);

	// Status byte seen by the host
	always_comb begin
		stat_byte = {stat_s[4], 3'h0, stat_s[3:2], stat_s[1], stat_s[0]};	// RULE7 RULE1
		if (stat_s[0]) begin
			stat_byte = SR_BUSY_READ;	// RULE17
		end
	end

	// Serial side: deselect or reset clears the output stage
	assign link_clr = spi_cs_n_in | ~reset_n_in;

	// Marks the first serial edge of each frame
	always_ff @(posedge spi_sck_in or posedge link_clr) begin
		if (link_clr) begin
			fresh <= 1'b1;	// RULE24
		end else begin
			fresh <= 1'b0;
		end
	end

	// Serial side next state, sampled on the rising edge
	always_comb begin
		logic [7:0]  sr_n;
		logic [15:0] a_n;
		logic        bdone;
		sr_n    = {lk.sr[6:0], spi_si_in};	// RULE23
		a_n     = {lk.addr[14:0], spi_si_in};
		bdone   = (lk.cnt[2:0] == 3'h7);
		next_lk = lk;
		buf_we  = 1'b0;
		rd_addr = lk.rd_ptr + 15'h1;	// RULE19
		if (lk.ph == PH_ADDR) begin
			rd_addr = a_n[ADDR_W-1:0];	// RULE12
		end
		next_lk.sr   = sr_n;
		next_lk.cnt  = (bdone && lk.ph != PH_ADDR) ? 4'h0 : lk.cnt + 4'h1;
		next_lk.tx   = {lk.tx[6:0], 1'b0};
		if (fresh) begin
			// New frame drops phase, count, kind and flags; page, mask and data are kept
			next_lk.ph        = PH_OPC;	// RULE20
			next_lk.cnt       = 4'h1;
			next_lk.sr        = {7'h0, spi_si_in};
			next_lk.kind      = K_NONE;
			next_lk.byte_seen = 1'b0;
			next_lk.boundary  = 1'b0;
			next_lk.tx_on     = 1'b0;
		end else begin
			unique case (lk.ph)
				PH_OPC: begin
					if (bdone) begin
						next_lk.ph = PH_IGN;
						if (stat_s[0] && sr_n != OP_STAT_RD) begin
							next_lk.kind = K_NONE;	// RULE14
						end else begin
							unique case (sr_n)	// RULE21 RULE22
								OP_SET_LATCH: begin
									next_lk.kind     = K_SET;
									next_lk.boundary = 1'b1;
								end
								OP_CLR_LATCH: begin
									next_lk.kind     = K_CLR;
									next_lk.boundary = 1'b1;
								end
								OP_STAT_RD: begin
									next_lk.ph    = PH_STAT;
									next_lk.tx    = stat_byte;
									next_lk.tx_on = 1'b1;
								end
								OP_STAT_WR: begin
									next_lk.kind = K_SWR;
									next_lk.ph   = PH_SDAT;
								end
								OP_ARR_RD: begin
									next_lk.kind = K_ARD;
									next_lk.ph   = PH_ADDR;
								end
								OP_ARR_WR: begin
									// Mask kept until here: programming reads it
									next_lk.kind = K_AWR;
									next_lk.ph   = PH_ADDR;
									next_lk.mask = '0;
								end
								default: begin
									next_lk.kind = K_NONE;
								end
							endcase
						end
					end
				end
				PH_ADDR: begin
					next_lk.addr = a_n;
					if (lk.cnt == 4'hf) begin
						next_lk.cnt = 4'h0;
						if (lk.kind == K_ARD) begin
							next_lk.ph     = PH_READ;
							next_lk.tx     = rd_data;
							next_lk.tx_on  = 1'b1;
							next_lk.rd_ptr = a_n[ADDR_W-1:0];
						end else begin
							next_lk.ph   = PH_WDAT;
							next_lk.page = a_n[ADDR_W-1:OFFS_W];
							next_lk.offs = a_n[OFFS_W-1:0];
						end
					end
				end
				PH_WDAT: begin
					next_lk.boundary = bdone;	// RULE26
					if (bdone) begin
						buf_we               = 1'b1;
						next_lk.mask[lk.offs] = 1'b1;
						next_lk.offs         = lk.offs + 6'h1;	// RULE15
						next_lk.byte_seen    = 1'b1;
					end
				end
				PH_SDAT: begin
					next_lk.boundary = bdone;
					if (bdone && !lk.byte_seen) begin
						next_lk.stat_data = sr_n;
						next_lk.byte_seen = 1'b1;
					end
				end
				PH_READ: begin
					if (bdone) begin
						next_lk.tx     = rd_data;	// RULE19
						next_lk.rd_ptr = rd_addr;
					end
				end
				PH_STAT: begin
					if (bdone) begin
						next_lk.tx = stat_byte;
					end
				end
				PH_IGN: begin
					next_lk.kind = K_NONE;	// RULE11
				end
			endcase
		end
	end

	// Serial side registers
	always_ff @(posedge spi_sck_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			lk <= '0;
		end else begin
			lk <= next_lk;
		end
	end

	// Output stage changes on the falling edge, released while deselected
	always_ff @(negedge spi_sck_in or posedge link_clr) begin
		if (link_clr) begin
			spi_so_out    <= 1'b0;
			spi_so_oe_out <= 1'b0;	// RULE24 RULE20
		end else begin
			spi_so_out    <= lk.tx[7] & lk.tx_on & ~fresh;	// RULE23
			spi_so_oe_out <= lk.tx_on & ~fresh;	// RULE22
		end
	end

	// Protection checks on the frame result
	always_comb begin
		logic [ADDR_W-1:0] base;
		base    = {lk.page, 6'h0};
		hw_lock = nv[2] & ~wg_s;	// RULE5
		unique case (nv[1:0])	// RULE4
			BP_NONE: page_prot = 1'b0;
			BP_QTR:  page_prot = (base >= PROT_QTR_BASE);
			BP_HALF: page_prot = (base >= PROT_HALF_BASE);
			BP_FULL: page_prot = 1'b1;
		endcase
	end

	// System side next state
	always_comb begin
		next_sy      = sy;
		arr_we       = 1'b0;
		nv_we        = 1'b0;
		next_sy.cs_q = cs_s;
		next_sy.wg_q = wg_s;
		// Frame start clears the abort; a guard fall in the same cycle wins
		if (sy.cs_q && !cs_s) begin
			next_sy.abort = 1'b0;
		end
		if (!cs_s && sy.wg_q && !wg_s && nv[2] && sy.st == EEPC_IDLE) begin
			next_sy.abort = 1'b1;	// RULE18
		end
		unique case (sy.st)
			EEPC_IDLE: begin
				if (!sy.cs_q && cs_s && lk.boundary) begin
					unique case (lk.kind)
						K_SET: next_sy.latch = 1'b1;	// RULE2 RULE11
						K_CLR: next_sy.latch = 1'b0;	// RULE2
						K_SWR: begin
							if (sy.latch && lk.byte_seen && !hw_lock && !sy.abort) begin
								nv_we         = 1'b1;	// RULE8 RULE6
								next_sy.busy  = 1'b1;	// RULE13
								next_sy.timer = '0;
								next_sy.st    = EEPC_WAIT;
							end
						end
						K_AWR: begin
							if (sy.latch && lk.byte_seen && !page_prot) begin
								next_sy.busy  = 1'b1;	// RULE13 RULE10 RULE25
								next_sy.timer = '0;
								next_sy.idx   = 7'h0;
								next_sy.st    = EEPC_PROG;
							end
						end
						default: begin
							next_sy.latch = sy.latch;
						end
					endcase
				end
			end
			EEPC_PROG: begin
				// Programs only bytes loaded into the page buffer
				arr_we        = lk.mask[sy.idx[OFFS_W-1:0]];
				next_sy.idx   = sy.idx + 7'h1;
				next_sy.timer = sy.timer + 17'h1;
				if (sy.idx == 7'(PAGE_BYTES - 1)) begin
					next_sy.st = EEPC_WAIT;
				end
			end
			EEPC_WAIT: begin
				next_sy.timer = sy.timer + 17'h1;	// RULE26
				if (sy.timer >= TIMER_LAST) begin
					next_sy.busy  = 1'b0;	// RULE1
					next_sy.latch = 1'b0;	// RULE16
					next_sy.st    = EEPC_IDLE;
				end
			end
		endcase
	end

	// System side registers; latch starts cleared
	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			sy      <= '0;	// RULE9
			sy.cs_q <= 1'b1;
			sy.wg_q <= 1'b1;
		end else begin
			sy <= next_sy;
		end
	end

endmodule

`default_nettype wire

// ==== test/eepc_chk.sv ====
/*
 * Port checker for the serial EEPROM command block.
 * Assumes mode-0 host framing with the serial clock at rest while deselected.
 */
`default_nettype none

module eepc_chk
	import eepc_pkg::*;
#(
	parameter int unsigned WRITE_CYCLES = WRITE_CYCLES_DEF
) (
	input wire logic clk_sys_in,
	input wire logic reset_n_in,
	input wire logic spi_sck_in,
	input wire logic spi_cs_n_in,
	input wire logic spi_si_in,
	input wire logic spi_wguard_n_in,
	input wire logic spi_so_out,
	input wire logic spi_so_oe_out
);
	typedef struct packed {
		logic [7:0] cnt;
		logic [7:0] op;
		logic [7:0] rx;
	} eepc_chk_st_t;

	eepc_chk_st_t st;
	eepc_chk_st_t next_st;

	// Frame bit count, opcode and first answer byte
	always_comb begin
		next_st = st;
		if (st.cnt != 8'hff) next_st.cnt = st.cnt + 8'h01;
		if (st.cnt < 8'h08) next_st.op = {st.op[6:0], spi_si_in};
		if (st.cnt >= 8'h08 && st.cnt < 8'h10) next_st.rx = {st.rx[6:0], spi_so_out};
	end

	// Cleared while deselected
	always_ff @(posedge spi_sck_in or posedge spi_cs_n_in or negedge reset_n_in) begin
		if (!reset_n_in || spi_cs_n_in) st <= '0;
		else st <= next_st;
	end

	property p_cs_idle;
		@(posedge clk_sys_in) disable iff (!reset_n_in)
		spi_cs_n_in [*2] |-> !spi_so_oe_out && !spi_so_out;
	endproperty
	a_cs_idle: assert property (p_cs_idle) else $error("output live while deselected");

	property p_so_quiet;
		@(posedge clk_sys_in) disable iff (!reset_n_in) !spi_so_oe_out |-> !spi_so_out;
	endproperty
	a_so_quiet: assert property (p_so_quiet) else $error("data while undriven");

	property p_op_silent;
		@(posedge spi_sck_in) disable iff (!reset_n_in) st.cnt < 8'h08 |-> !spi_so_oe_out;
	endproperty
	a_op_silent: assert property (p_op_silent) else $error("output during opcode");

	property p_oe_cmd;
		@(posedge spi_sck_in) disable iff (!reset_n_in)
		spi_so_oe_out |-> st.op == OP_STAT_RD || st.op == OP_ARR_RD;
	endproperty
	a_oe_cmd: assert property (p_oe_cmd) else $error("output for silent opcode");

	property p_stat_first;
		@(posedge spi_sck_in) disable iff (!reset_n_in)
		st.cnt == 8'h08 && st.op == OP_STAT_RD |-> spi_so_oe_out;
	endproperty
	a_stat_first: assert property (p_stat_first) else $error("status not answered");

	property p_rd_lat;
		@(posedge spi_sck_in) disable iff (!reset_n_in)
		st.op == OP_ARR_RD && st.cnt < 8'h18 |-> !spi_so_oe_out;
	endproperty
	a_rd_lat: assert property (p_rd_lat) else $error("read data before address end");

	property p_stat_fmt;
		@(posedge spi_sck_in) disable iff (!reset_n_in)
		st.cnt == 8'h0f && st.op == OP_STAT_RD |->
			{st.rx[6:0], spi_so_out} == SR_BUSY_READ || (st.rx[5:3] == 3'h0 && !spi_so_out);
	endproperty
	a_stat_fmt: assert property (p_stat_fmt) else $error("bad status byte");

	property p_oe_hold;
		@(posedge spi_sck_in) disable iff (!reset_n_in)
		spi_so_oe_out |=> spi_so_oe_out || st.cnt == 8'h00;
	endproperty
	a_oe_hold: assert property (p_oe_hold) else $error("output dropped in frame");
endmodule

bind eepc_top eepc_chk #(.WRITE_CYCLES(WRITE_CYCLES)) eepc_chk_inst (
	.clk_sys_in     (clk_sys_in),
	.reset_n_in     (reset_n_in),
	.spi_sck_in     (spi_sck_in),
	.spi_cs_n_in    (spi_cs_n_in),
	.spi_si_in      (spi_si_in),
	.spi_wguard_n_in(spi_wguard_n_in),
	.spi_so_out     (spi_so_out),
	.spi_so_oe_out  (spi_so_oe_out)
);

`default_nettype wire

// ==== test/eepc_host.sv ====
/*
 * Host serial master model: frames each command with chip select.
 * Assumes a mode-0 device that changes its output on falling edges.
 */
`default_nettype none

module eepc_host (
	output var logic sck_out,
	output var logic cs_n_out,
	output var logic si_out,
	input  wire logic so_in
);
	timeunit 1ns;
	timeprecision 1ps;

	// Deselected, clock at rest
	initial begin
		sck_out = 1'b0;
		cs_n_out = 1'b1;
		si_out = 1'b0;
	end

	// One frame, 12 ns clock; answer taken at every rising edge
	task automatic xfer(input logic [7:0] tx[$], output logic [7:0] rx[$]);
		logic [7:0] b;
		b = 8'h00;
		rx = {};
		cs_n_out = 1'b0;
		#20;
		foreach (tx[i]) begin
			for (int k = 7; k >= 0; k--) begin
				si_out = tx[i][k];
				#6;
				sck_out = 1'b1;
				b = {b[6:0], so_in};
				#6;
				sck_out = 1'b0;
			end
			rx.push_back(b);
		end
		#20;
		cs_n_out = 1'b1;
		si_out = ~si_out;
		#200;
	endtask
endmodule

`default_nettype wire

// ==== test/tb.sv ====
/*
 * Self-checking bench for the serial EEPROM command block.
 * Assumes the host model frames commands and a short write time.
 */
`default_nettype none

module tb
	import eepc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int unsigned WR_CYC = 100;
	localparam int LIMIT = 20000;

	logic       clk_sys;
	logic       reset_n;
	logic       wguard_n;
	logic       sck, cs_n, si, so, so_oe;
	int         fail_count = 0;
	int         compares = 0;
	int         cycles = 0;
	logic [7:0] r[$];

	eepc_top #(.WRITE_CYCLES(WR_CYC)) eepc_top_inst (
		.clk_sys_in     (clk_sys),
		.reset_n_in     (reset_n),
		.spi_sck_in     (sck),
		.spi_cs_n_in    (cs_n),
		.spi_si_in      (si),
		.spi_wguard_n_in(wguard_n),
		.spi_so_out     (so),
		.spi_so_oe_out  (so_oe)
	);

	eepc_host eepc_host_inst (
		.sck_out (sck),
		.cs_n_out(cs_n),
		.si_out  (si),
		.so_in   (so)
	);

	// System clock
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end

	// Hang guard
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == LIMIT) begin
			fail_count++;
			end_sim();
		end
	end

	task automatic end_sim();
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cmd(input logic [7:0] op);
		eepc_host_inst.xfer('{op}, r);
	endtask

	task automatic stat(input logic [7:0] exp);
		eepc_host_inst.xfer('{OP_STAT_RD, 8'h00}, r);
		chk(r[1], exp);
	endtask

	task automatic swr(input logic [7:0] v);
		cmd(OP_SET_LATCH);
		eepc_host_inst.xfer('{OP_STAT_WR, v}, r);
	endtask

	task automatic wr(input logic en, input logic [15:0] a, input logic [7:0] d[$]);
		logic [7:0] q[$];
		q = d;
		if (en) cmd(OP_SET_LATCH);
		q.push_front(a[7:0]);
		q.push_front(a[15:8]);
		q.push_front(OP_ARR_WR);
		eepc_host_inst.xfer(q, r);
	endtask

	task automatic rd(input logic [15:0] a, input logic [7:0] e[$]);
		logic [7:0] q[$];
		q = '{OP_ARR_RD, a[15:8], a[7:0]};
		foreach (e[i]) q.push_back(8'h00);
		eepc_host_inst.xfer(q, r);
		foreach (e[i]) chk(r[3 + i], e[i]);
	endtask

	// Poll status until not busy, bounded
	task automatic idle();
		repeat (40) begin
			eepc_host_inst.xfer('{OP_STAT_RD, 8'h00}, r);
			if (r[1] !== 8'hff) break;
		end
	endtask

	task automatic guard(input logic v);
		@(posedge clk_sys);
		#1;
		wguard_n = v;
	endtask

	task automatic t_reset();
		stat(8'h00);
		cmd(8'hab);
		stat(8'h00);
	endtask

	task automatic t_latch();
		cmd(OP_SET_LATCH);
		stat(8'h02);
		cmd(OP_CLR_LATCH);
		stat(8'h00);
	endtask

	// 65 bytes into one page: the last overwrites the first
	task automatic t_page();
		logic [7:0] d[$];
		for (int i = 0; i < 65; i++) d.push_back(8'(i));
		wr(1'b1, 16'h807e, d);
		stat(8'hff);
		rd(16'h007e, '{8'h00});
		idle();
		stat(8'h00);
		rd(16'h007e, '{8'h40, 8'h01});
		rd(16'h0040, '{8'h02});
	endtask

	task automatic t_refuse();
		wr(1'b0, 16'h007e, '{8'h55});
		stat(8'h00);
		rd(16'h007e, '{8'h40});
	endtask

	task automatic t_wrap();
		wr(1'b1, 16'h7fff, '{8'hc1});
		idle();
		wr(1'b1, 16'h0000, '{8'hc2});
		idle();
		rd(16'h7fff, '{8'hc1, 8'hc2});
	endtask

	task automatic t_prot();
		logic [14:0] base[3] = '{15'h6000, 15'h4000, 15'h0000};
		for (int c = 1; c < 4; c++) begin
			swr({4'h7, c[1:0], 2'h3});
			idle();
			stat({4'h0, c[1:0], 2'h0});
			wr(1'b1, {1'b0, base[c - 1]}, '{8'h5a});
			stat({4'h0, c[1:0], 2'h2});
			if (c < 3) begin
				wr(1'b0, {1'b0, base[c - 1] - 15'h0001}, '{8'h5a});
				stat(8'hff);
				idle();
				rd({1'b0, base[c - 1] - 15'h0001}, '{8'h5a});
			end
		end
	endtask

	task automatic t_hw();
		swr(8'h80);
		idle();
		stat(8'h80);
		guard(1'b0);
		swr(8'h0c);
		stat(8'h82);
		wr(1'b0, 16'h0200, '{8'h77});
		stat(8'hff);
		idle();
		guard(1'b1);
		cmd(OP_SET_LATCH);
		fork
			eepc_host_inst.xfer('{OP_STAT_WR, 8'h8c}, r);
			begin
				guard(1'b0);
				repeat (2) @(posedge clk_sys);
				guard(1'b1);
			end
		join
		stat(8'h82);
		swr(8'h00);
		idle();
		stat(8'h00);
	endtask

	// Main sequence
	initial begin
		wguard_n = 1'b1;
		reset_n = 1'b0;
		repeat (8) @(posedge clk_sys);
		#1;
		reset_n = 1'b1;
		repeat (4) @(posedge clk_sys);
		t_reset();
		t_latch();
		t_page();
		t_refuse();
		t_wrap();
		t_prot();
		t_hw();
		end_sim();
	end
endmodule

`default_nettype wire
